// ### design/hub_sideband_top.sv
// Sideband pin logic of a three-port hub: reset, reference clock, power
// sensing, suspend and speed indicators, lamp and configuration straps.
// Assumes the hub core runs on i_mclk and presents its state on plain inputs.
`timescale 1ns/100ps
`default_nettype none
module hub_sideband_top
    import hub_sideband_pkg::*;
#(
    parameter int unsigned WAKE_PULSE_CYC = WAKE_PULSE_CYCLES,
    parameter int unsigned LED_STEP_CYC   = LED_STEP_CYCLES
)
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_reset_n,
    input  wire logic       i_crystal_in,
    input  wire logic       i_reference_clock_in,
    input  wire logic       i_ref_single_ended,
    input  wire logic       i_upstream_power_sense,
    input  wire logic       i_self_power_sense,
    input  wire logic       i_config_method_strap_lo,
    input  wire logic       i_config_method_strap_hi,
    input  wire logic       i_fixed_port_strap_lo,
    input  wire logic       i_fixed_port_strap_hi,
    input  wire logic       i_configured,
    input  wire logic       i_suspended,
    input  wire logic       i_connected,
    input  wire logic       i_high_speed,
    input  wire logic       i_wake_mode,
    input  wire logic       i_remote_wake_event,
    input  wire logic       i_lamp_enable,
    input  wire led_mode_t  i_lamp_mode,
    input  wire logic [1:0] i_lamp_rate,
    output logic            o_crystal_out,
    output logic            o_crystal_out_oe,
    output logic            o_ref_clock_ok,
    output logic            o_core_reset,
    output logic            o_upstream_attach,
    output logic            o_renegotiate,
    output logic            o_self_powered,
    output logic            o_suspend_wakeup_indicator,
    output logic            o_suspend_wakeup_indicator_oe,
    output logic            o_high_speed_indicator,
    output logic            o_general_indicator_lamp,
    output logic [1:0]      o_config_method,
    output logic [1:0]      o_fixed_ports,
    output logic            o_straps_valid
);
    sideband_if sb ();

    link_state_t link_q;
    link_state_t link_d;
    logic        power_prev_q;
    logic        power_toggle;
    logic [15:0] reneg_cnt_q;
    logic [15:0] wake_cnt_q;
    logic        wake_busy;
    logic        ref_prev_q;
    logic        ref_sel;
    logic [4:0]  ref_idle_q;
    logic        susp_level;

    pin_sync u_sync (
        .i_mclk                   (i_mclk),
        .i_rst                    (i_rst),
        .i_reset_n                (i_reset_n),
        .i_upstream_power_sense   (i_upstream_power_sense),
        .i_self_power_sense       (i_self_power_sense),
        .i_crystal_in             (i_crystal_in),
        .i_reference_clock_in     (i_reference_clock_in),
        .i_ref_single_ended       (i_ref_single_ended),
        .i_config_method_strap_lo (i_config_method_strap_lo),
        .i_config_method_strap_hi (i_config_method_strap_hi),
        .i_fixed_port_strap_lo    (i_fixed_port_strap_lo),
        .i_fixed_port_strap_hi    (i_fixed_port_strap_hi),
        .sb                       (sb)
    );

    led_pattern #(
        .STEP_CYC (LED_STEP_CYC)
    ) u_led (
        .i_mclk   (i_mclk),
        .i_rst    (sb.core_rst),
        .i_enable (i_lamp_enable),
        .i_mode   (i_lamp_mode),
        .i_rate   (i_lamp_rate),
        .o_lamp   (o_general_indicator_lamp)
    );

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= sb.core_rst;
        end
    end

    // Reference presence: the selected source must keep toggling. The
    // crystal driver is released when a single-ended oscillator is used.
    assign ref_sel = sb.ref_single_ended ? sb.ref_level : sb.crystal_level;

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            ref_prev_q     <= 1'b0;
            ref_idle_q     <= 5'h00;
            o_ref_clock_ok <= 1'b0;
        end else begin
            ref_prev_q <= ref_sel;
            if (ref_sel != ref_prev_q) begin
                ref_idle_q     <= 5'h00;
                o_ref_clock_ok <= 1'b1;
            end else if (ref_idle_q == 5'(REF_TIMEOUT_CYCLES)) begin
                o_ref_clock_ok <= 1'b0;
            end else begin
                ref_idle_q <= ref_idle_q + 5'h01;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            o_crystal_out    <= 1'b0;
            o_crystal_out_oe <= 1'b0;
        end else begin
            o_crystal_out    <= ~sb.crystal_level;
            o_crystal_out_oe <= ~sb.ref_single_ended;
        end
    end

    // Upstream link: any edge on the power sense drops the attachment until the sense
    // has been steady for a fixed gap, then reattaches if power is present. Only link state moves.
    assign power_toggle = (sb.upstream_power != power_prev_q);

    always_comb begin
        link_d = link_q;
        unique case (link_q)
            LS_DETACHED: begin
                if (sb.upstream_power) begin
                    link_d = LS_ATTACHED;
                end
            end
            LS_ATTACHED: begin
                if (power_toggle) begin
                    link_d = LS_RENEG;
                end
            end
            LS_RENEG: begin
                if (power_toggle) begin
                    link_d = LS_RENEG;
                end else if (reneg_cnt_q == 16'(RENEG_CYCLES - 1)) begin
                    link_d = LS_DETACHED;
                end
            end
            default: begin
                link_d = LS_DETACHED;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            link_q       <= LS_DETACHED;
            power_prev_q <= 1'b0;
            reneg_cnt_q  <= COUNT_RESET;
        end else begin
            link_q       <= link_d;
            power_prev_q <= sb.upstream_power;
            if (link_d != LS_RENEG || power_toggle) begin
                reneg_cnt_q <= COUNT_RESET;
            end else begin
                reneg_cnt_q <= reneg_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            o_upstream_attach <= 1'b0;
            o_renegotiate     <= 1'b0;
        end else begin
            o_upstream_attach <= (link_d == LS_ATTACHED);
            o_renegotiate     <= (link_q == LS_ATTACHED) && power_toggle;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            o_self_powered <= 1'b0;
        end else begin
            o_self_powered <= sb.self_power;
        end
    end

    // Suspend or wakeup indicator, open drain: low is driven, high released.
    assign wake_busy = (wake_cnt_q != COUNT_RESET);

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst || i_wake_mode == IND_SUSPEND) begin
            wake_cnt_q <= COUNT_RESET;
        end else if (wake_busy) begin
            if (wake_cnt_q == 16'(WAKE_PULSE_CYC)) begin
                wake_cnt_q <= COUNT_RESET;
            end else begin
                wake_cnt_q <= wake_cnt_q + 16'h0001;
            end
        end else if (i_remote_wake_event) begin
            wake_cnt_q <= 16'h0001;
        end
    end

    always_comb begin
        if (i_wake_mode == IND_WAKE) begin
            susp_level = !(wake_busy || i_remote_wake_event);
        end else begin
            susp_level = i_configured && !i_suspended;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            o_suspend_wakeup_indicator    <= 1'b0;
            o_suspend_wakeup_indicator_oe <= 1'b1;
        end else begin
            o_suspend_wakeup_indicator    <= susp_level;
            o_suspend_wakeup_indicator_oe <= !susp_level;
        end
    end

    // Speed indicator polarity comes from the latched method strap hi bit.
    always_ff @(posedge i_mclk) begin
        if (sb.core_rst || !sb.straps_valid) begin
            o_high_speed_indicator <= 1'b0;
        end else begin
            o_high_speed_indicator <= (i_connected && i_high_speed) ^ sb.config_method[1];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sb.core_rst) begin
            o_config_method <= STRAP_RESET;
            o_fixed_ports   <= STRAP_RESET;
            o_straps_valid  <= 1'b0;
        end else begin
            o_config_method <= sb.config_method;
            o_fixed_ports   <= sb.fixed_ports;
            o_straps_valid  <= sb.straps_valid;
        end
    end

    a_reset_clears_outputs: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        sb.core_rst |=> (!o_upstream_attach && !o_self_powered && !o_straps_valid && o_core_reset))
        else $error("Outputs not at reset values during internal reset.");

    a_ref_lost_flag: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (ref_idle_q == 5'(REF_TIMEOUT_CYCLES) && ref_sel == ref_prev_q) |=> !o_ref_clock_ok)
        else $error("Reference reported present after it stopped toggling.");

    a_reneg_drops_attach: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (link_q == LS_ATTACHED && power_toggle) |=> (!o_upstream_attach && o_renegotiate && sb.straps_valid))
        else $error("Power toggle did not drop the link cleanly.");

    a_wake_pulse_low: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (i_wake_mode && i_remote_wake_event) |=> o_suspend_wakeup_indicator_oe ##1 (!i_wake_mode || o_suspend_wakeup_indicator_oe))
        else $error("Wakeup event did not pull the indicator low.");

    a_suspend_level_map: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        !i_wake_mode |=> (o_suspend_wakeup_indicator == $past(i_configured && !i_suspended)))
        else $error("Suspend indicator level does not follow configured and active state.");

    a_self_power_pin: assert property (
        @(posedge i_mclk) disable iff (i_rst || sb.core_rst || o_core_reset)
        o_self_powered == $past(i_self_power_sense, 3))
        else $error("Self power output does not follow the sense pin.");

    a_hs_speed_level: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (sb.straps_valid && !sb.config_method[1] && i_connected) |=> (o_high_speed_indicator == $past(i_high_speed)))
        else $error("Speed indicator wrong for active-high polarity.");

    a_hs_active_low: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (sb.straps_valid && sb.config_method[1]) |=> (o_high_speed_indicator == !$past(i_connected && i_high_speed)))
        else $error("Speed indicator wrong for active-low polarity.");

    a_method_strap_out: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (sb.straps_valid && o_straps_valid) |-> (o_config_method == $past(sb.config_method)))
        else $error("Configuration method output differs from the latched straps.");

    a_fixed_strap_out: assert property (
        @(posedge i_mclk) disable iff (sb.core_rst)
        (sb.straps_valid && o_straps_valid) |-> (o_fixed_ports == $past(sb.fixed_ports)))
        else $error("Fixed port output differs from the latched straps.");
endmodule : hub_sideband_top
`default_nettype wire

// ### design/hub_sideband_pkg.sv
// Constants and types shared by the hub sideband pin logic.
// Assumes a single 50 MHz system clock; all times are turned into cycles here.
package hub_sideband_pkg;
    localparam int unsigned MCLK_PERIOD_NS     = 20;
    localparam int unsigned REF_CLOCK_MHZ      = 24;
    localparam int unsigned RESET_MIN_NS       = 5000;
    localparam int unsigned RESET_MIN_CYCLES   = (RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned RENEG_GAP_NS       = 10000;
    localparam int unsigned RENEG_CYCLES       = (RENEG_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned WAKE_PULSE_US      = 1000;
    localparam int unsigned WAKE_PULSE_CYCLES  = (WAKE_PULSE_US * 1000) / MCLK_PERIOD_NS;
    localparam int unsigned LED_STEP_US        = 1000;
    localparam int unsigned LED_STEP_CYCLES    = (LED_STEP_US * 1000) / MCLK_PERIOD_NS;
    localparam int unsigned REF_TIMEOUT_CYCLES = 16;
    localparam int unsigned SYNC_BITS          = 10;
    localparam logic [1:0]  STRAP_RESET        = 2'h0;
    localparam logic [15:0] COUNT_RESET        = 16'h0000;

    typedef enum logic [1:0] {
        LS_DETACHED = 2'b00,
        LS_ATTACHED = 2'b01,
        LS_RENEG    = 2'b10
    } link_state_t;

    typedef enum logic {
        IND_SUSPEND = 1'b0,
        IND_WAKE    = 1'b1
    } ind_mode_t;

    typedef enum logic {
        LED_BLINK   = 1'b0,
        LED_BREATHE = 1'b1
    } led_mode_t;
endpackage : hub_sideband_pkg

// ### design/sideband_if.sv
// Carrier for synchronised pins, the internal reset and latched straps.
// Assumes one producer (pin_sync) and one consumer (the top module).
`timescale 1ns/100ps
`default_nettype none
interface sideband_if;
    logic       core_rst;
    logic       upstream_power;
    logic       self_power;
    logic       crystal_level;
    logic       ref_level;
    logic       ref_single_ended;
    logic       straps_valid;
    logic [1:0] config_method;
    logic [1:0] fixed_ports;

    modport producer (
        output core_rst, upstream_power, self_power, crystal_level, ref_level,
        output ref_single_ended, straps_valid, config_method, fixed_ports
    );
    modport consumer (
        input core_rst, upstream_power, self_power, crystal_level, ref_level,
        input ref_single_ended, straps_valid, config_method, fixed_ports
    );
endinterface : sideband_if
`default_nettype wire

// ### design/pin_sync.sv
// Pin synchronisers, internal reset generation and strap capture.
// Assumes every pin input is asynchronous to i_mclk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import hub_sideband_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_reset_n,
    input  wire logic i_upstream_power_sense,
    input  wire logic i_self_power_sense,
    input  wire logic i_crystal_in,
    input  wire logic i_reference_clock_in,
    input  wire logic i_ref_single_ended,
    input  wire logic i_config_method_strap_lo,
    input  wire logic i_config_method_strap_hi,
    input  wire logic i_fixed_port_strap_lo,
    input  wire logic i_fixed_port_strap_hi,
    sideband_if.producer sb
);
    logic [SYNC_BITS-1:0] raw;
    logic [SYNC_BITS-1:0] s1_q;
    logic [SYNC_BITS-1:0] s2_q;
    logic                 core_rst_q;
    logic                 valid_q;
    logic [1:0]           method_q;
    logic [1:0]           fixed_q;

    assign raw = {i_fixed_port_strap_hi, i_fixed_port_strap_lo, i_config_method_strap_hi,
                  i_config_method_strap_lo, i_ref_single_ended, i_reference_clock_in,
                  i_crystal_in, i_self_power_sense, i_upstream_power_sense, i_reset_n};

    genvar g;
    generate
        for (g = 0; g < SYNC_BITS; g++) begin : g_sync
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    // Full reset while the pin is low, with no filtering of short pulses.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            core_rst_q <= 1'b1;
        end else begin
            core_rst_q <= ~s2_q[0];
        end
    end

    // Straps are caught once, on the first cycle after reset ends.
    always_ff @(posedge i_mclk) begin
        if (core_rst_q) begin
            valid_q  <= 1'b0;
            method_q <= STRAP_RESET;
            fixed_q  <= STRAP_RESET;
        end else if (!valid_q) begin
            valid_q  <= 1'b1;
            method_q <= s2_q[7:6];
            fixed_q  <= s2_q[9:8];
        end
    end

    assign sb.core_rst         = core_rst_q;
    assign sb.upstream_power   = s2_q[1];
    assign sb.self_power       = s2_q[2];
    assign sb.crystal_level    = s2_q[3];
    assign sb.ref_level        = s2_q[4];
    assign sb.ref_single_ended = s2_q[5];
    assign sb.straps_valid     = valid_q;
    assign sb.config_method    = method_q;
    assign sb.fixed_ports      = fixed_q;

    a_pin_reset_full: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        !i_reset_n |-> ##3 core_rst_q)
        else $error("Low reset pin did not raise the internal reset.");

    a_strap_hold_stable: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (valid_q && !core_rst_q) |=> (core_rst_q || $stable(method_q) && $stable(fixed_q)))
        else $error("Latched straps changed before the next reset.");
endmodule : pin_sync
`default_nettype wire

// ### design/led_pattern.sv
// Blink and breathe pattern generator for the general indicator lamp.
// Assumes a synchronous reset from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module led_pattern
    import hub_sideband_pkg::*;
#(
    parameter int unsigned STEP_CYC = LED_STEP_CYCLES
)
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_enable,
    input  wire led_mode_t  i_mode,
    input  wire logic [1:0] i_rate,
    output logic            o_lamp
);
    logic [15:0] step_cnt_q;
    logic [7:0]  phase_q;
    logic [6:0]  pwm_q;
    logic [6:0]  level;

    // The step prescaler sets the pace; the rate sets the phase increment.
    always_ff @(posedge i_mclk) begin
        if (i_rst || !i_enable) begin
            step_cnt_q <= COUNT_RESET;
            phase_q    <= 8'h00;
        end else if (step_cnt_q == 16'(STEP_CYC - 1)) begin
            step_cnt_q <= COUNT_RESET;
            phase_q    <= phase_q + 8'({6'h00, i_rate} + 8'h01);
        end else begin
            step_cnt_q <= step_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pwm_q <= 7'h00;
        end else begin
            pwm_q <= pwm_q + 7'h01;
        end
    end

    assign level = phase_q[7] ? ~phase_q[6:0] : phase_q[6:0];

    always_ff @(posedge i_mclk) begin
        if (i_rst || !i_enable) begin
            o_lamp <= 1'b0;
        end else if (i_mode == LED_BREATHE) begin
            o_lamp <= (pwm_q < level);
        end else begin
            o_lamp <= phase_q[7];
        end
    end

    a_led_off_disabled: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        !i_enable |=> !o_lamp)
        else $error("Lamp lit while the lamp output was not enabled.");
endmodule : led_pattern
`default_nettype wire

// ### testbench/hub_board_model.sv
// Board-side model: external reset logic and a free-running 24 MHz oscillator.
// Assumes i_mclk is the 50 MHz system clock of the hub.
`timescale 1ns/100ps
`default_nettype none
module hub_board_model
    import hub_sideband_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_pulse,
    output logic      o_reset_n,
    output var logic  o_ref
);
    int unsigned cnt_q;
    initial o_ref = 1'b0;
    always #20.833 o_ref = ~o_ref;
    // A request holds the reset pin low for the full minimum width.
    always_ff @(posedge i_mclk) begin
        if (i_pulse)
            cnt_q <= RESET_MIN_CYCLES;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
    assign o_reset_n = (cnt_q == 0);
endmodule : hub_board_model
`default_nettype wire

// ### testbench/test_hub_sideband_top.sv
// Testbench for the hub sideband pin logic: drives core state and pins, checks outputs.
// Assumes the board model supplies the reset pin and the reference oscillator.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
`define WAITF(n, e, b) begin wk = 0; while (!(e) && wk < b) begin tick(1); wk++; end `CHK(n, 1'b1, e) if (!(e)) test_done(); end
module test_hub_sideband_top;
    import hub_sideband_pkg::*;
    logic       i_mclk = 1'b0;
    logic       i_rst = 1'b1;
    logic       pulse = 1'b0, sel = 1'b0, upw = 1'b1, spw = 1'b0, lseen = 1'b0;
    logic [1:0] cm = 2'h1, fp = 2'h2, rate = 2'h3;
    logic       cfgd = 1'b0, susp = 1'b0, conn = 1'b0, hs = 1'b0, wmode = 1'b0, wev = 1'b0, len = 1'b0;
    logic       rst_n, ref_clk, xo_oe, ref_ok, core_rst, attach, reneg, selfp, ind, hsi, lamp, valid;
    logic       xo, ind_oe, lprev, xen = 1'b1;
    led_mode_t  lmode = LED_BLINK;
    logic [1:0] o_cm, o_fp;
    int         err_count = 0, checked = 0, wk, k, tg;
    always #10 i_mclk = ~i_mclk;
    hub_board_model i_board (.i_mclk(i_mclk), .i_pulse(pulse), .o_reset_n(rst_n), .o_ref(ref_clk));
    hub_sideband_top #(.WAKE_PULSE_CYC(8), .LED_STEP_CYC(4)) i_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_n(rst_n), .i_crystal_in(ref_clk & xen),
        .i_reference_clock_in(ref_clk), .i_ref_single_ended(sel), .i_upstream_power_sense(upw),
        .i_self_power_sense(spw), .i_config_method_strap_lo(cm[0]), .i_config_method_strap_hi(cm[1]),
        .i_fixed_port_strap_lo(fp[0]), .i_fixed_port_strap_hi(fp[1]), .i_configured(cfgd),
        .i_suspended(susp), .i_connected(conn), .i_high_speed(hs), .i_wake_mode(wmode),
        .i_remote_wake_event(wev), .i_lamp_enable(len), .i_lamp_mode(lmode), .i_lamp_rate(rate),
        .o_crystal_out(xo), .o_crystal_out_oe(xo_oe), .o_ref_clock_ok(ref_ok), .o_core_reset(core_rst),
        .o_upstream_attach(attach), .o_renegotiate(reneg), .o_self_powered(selfp),
        .o_suspend_wakeup_indicator(ind), .o_suspend_wakeup_indicator_oe(ind_oe), .o_high_speed_indicator(hsi),
        .o_general_indicator_lamp(lamp), .o_config_method(o_cm), .o_fixed_ports(o_fp), .o_straps_valid(valid));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick
    initial begin
        tick(4);
        @(posedge i_mclk) i_rst <= 1'b0;
        `WAITF("valid", valid, 20)
        `CHK("method", 2'h1, o_cm)
        `CHK("fixed", 2'h2, o_fp)
        @(posedge i_mclk) cm <= 2'h2;
        fp <= 2'h1;
        tick(5);
        `CHK("method held", 2'h1, o_cm)
        `CHK("fixed held", 2'h2, o_fp)
        $display("straps done");
        @(posedge i_mclk) spw <= 1'b1;
        tick(4);
        `CHK("selfpow", 1'b1, selfp)
        @(posedge i_mclk) spw <= 1'b0;
        tick(4);
        `CHK("buspow", 1'b0, selfp)
        for (k = 0; k < 4; k++) begin
            @(posedge i_mclk) {cfgd, susp} <= k[1:0];
            tick(2);
            `CHK("suspend_wakeup_indicator", k == 2, ind)
        end
        @(posedge i_mclk) conn <= 1'b1;
        hs <= 1'b1;
        tick(2);
        `CHK("hs", 1'b1, hsi)
        @(posedge i_mclk) hs <= 1'b0;
        tick(2);
        `CHK("fs", 1'b0, hsi)
        $display("indicators done");
        `WAITF("attach", attach, 600)
        @(posedge i_mclk) upw <= 1'b0;
        `WAITF("reneg", reneg, 10)
        `CHK("detach", 1'b0, attach)
        `CHK("no reset", 1'b0, core_rst)
        @(posedge i_mclk) upw <= 1'b1;
        `WAITF("reattach", attach, 1200)
        `CHK("kept", 1'b1, valid)
        $display("renegotiate done");
        @(posedge i_mclk) wmode <= 1'b1;
        cfgd <= 1'b1;
        susp <= 1'b0;
        @(posedge i_mclk) wev <= 1'b1;
        @(posedge i_mclk) wev <= 1'b0;
        `WAITF("wake low", !ind, 4)
        `CHK("wake oe", 1'b1, ind_oe)
        `WAITF("wake rel", ind, 30)
        $display("wake done");
        repeat (300) begin
            tick(1);
            lseen |= lamp;
        end
        `CHK("lamp off", 1'b0, lseen)
        @(posedge i_mclk) len <= 1'b1;
        `WAITF("lamp on", lamp, 1000)
        @(posedge i_mclk) lmode <= LED_BREATHE;
        rate <= 2'h0;
        tg = 0;
        tick(2);
        lprev = lamp;
        repeat (256) begin
            tick(1);
            if (lamp !== lprev) tg++;
            lprev = lamp;
        end
        `CHK("breathe", 1'b1, tg >= 3)
        $display("lamp done");
        `WAITF("xtal ok", ref_ok, 40)
        `CHK("xo oe", 1'b1, xo_oe)
        @(posedge i_mclk) sel <= 1'b1;
        tick(5);
        `CHK("xo off", 1'b0, xo_oe)
        `WAITF("ref ok", ref_ok, 40)
        @(posedge i_mclk) sel <= 1'b0;
        xen <= 1'b0;
        `WAITF("ref lost", !ref_ok, 60)
        `CHK("xo idle", 1'b1, xo)
        $display("reference done");
        @(posedge i_mclk) pulse <= 1'b1;
        @(posedge i_mclk) pulse <= 1'b0;
        `WAITF("core rst", core_rst, 10)
        `CHK("rst attach", 1'b0, attach)
        `CHK("rst valid", 1'b0, valid)
        `WAITF("revalid", valid, 400)
        `CHK("method2", 2'h2, o_cm)
        `CHK("fixed2", 2'h1, o_fp)
        tick(2);
        `CHK("hs low act", 1'b1, hsi)
        $display("reset pin done");
        test_done();
    end
endmodule : test_hub_sideband_top
`default_nettype wire
